// ===== design/eiu_pkg.sv
// shared constants and carriers for the external pin interrupt unit
package eiu_pkg;
   localparam int          EIU_ADDR_W   = 12;
   localparam int          EIU_LINES    = 8;
   // register indices; byte address is four times the index
   localparam logic [9:0]  IDX_FLAGS    = 10'h038;
   localparam logic [9:0]  IDX_MASK     = 10'h039;
   localparam logic [9:0]  IDX_SENSE_HI = 10'h03a;
   localparam logic [9:0]  IDX_SENSE_LO = 10'h06a;
   localparam logic [7:0]  RST_FLAGS    = 8'h00;
   localparam logic [7:0]  RST_MASK     = 8'h00;
   localparam logic [7:0]  RST_SENSE    = 8'h00;
   // sense field codes, two bits per line, line n at bits 2n+1:2n
   localparam logic [1:0]  SENSE_LEVEL  = 2'h0;
   localparam logic [1:0]  SENSE_CHANGE = 2'h1;
   localparam logic [1:0]  SENSE_FALL   = 2'h2;
   localparam logic [1:0]  SENSE_RISE   = 2'h3;
   localparam int          SENSE_W      = 2;
   localparam int          FIRST_UPPER  = 4;
   // timing
   localparam int          CLK_PERIOD_NS = 50;
   localparam int          PULSE_MIN_NS  = 50;
   localparam int          PULSE_MIN_CYC =
      (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          APB_WAIT_CYC  = 1;

   typedef struct packed {
      logic                  psel;
      logic                  penable;
      logic                  pwrite;
      logic [EIU_ADDR_W-1:0] paddr;
      logic [31:0]           pwdata;
   } eiu_apb_req_t;

   typedef struct packed {
      logic                  pready;
      logic [31:0]           prdata;
      logic                  pslverr;
   } eiu_apb_rsp_t;
endpackage

// ===== design/eiu_ext_irq.sv
// external pin interrupt unit: eight lines, APB registers, one irq
// Function
// - lines 0-3 sense: 00 low level, 01 reserved, 10 falling, 11 rising
// - lines 4-7 sense: 00 low level, 01 any change, 10 fall, 11 rise
// - request reaches core only with line enable and global enable set
// - lines 0-3 catch edges on pulses of 50 ns or more
// - lines 4-7 sample pins; pulses over one clock always request
// - level mode requests continuously while the pin stays low
// - detection uses pin level even when pin is an output
// - edge or change sets the line's request flag
// - flag clears when the core takes that line's vector
// - writing one clears a flag; writing zero leaves it
// - level-sensed lines keep their flag at zero always
// - sleep with lines 0-3 disabled clamps inputs; may set flags
// - sense change while enabled may request; not suppressed
// - registers reset to zero; legacy mode hides lower sense register
// - all lines need clock, level mode and lines 0-3 included; none detect without it
`timescale 1ns/100ps
module eiu_ext_irq
   import eiu_pkg::*;
#(
   parameter int LINES = EIU_LINES // lines served; only eight fit the map
)
(
   input  wire logic         i_clock,             // 20 MHz clock
   input  wire logic         i_reset,             // sync, active high
   input  wire eiu_apb_req_t i_apb,               // apb request
   output eiu_apb_rsp_t      o_apb,               // apb response
   input  wire logic [7:0]   i_ext_irq_pins,      // interrupt pins
   input  wire logic         i_global_irq_enable, // core global enable
   input  wire logic         i_vector_taken,      // core takes a vector
   input  wire logic [2:0]   i_vector_line,       // line of that vector
   input  wire logic         i_sleep,             // deep sleep active
   input  wire logic         i_compat_mode,       // legacy mode strap
   output logic [7:0]        o_line_request,      // per-line request
   output logic              o_irq                // request to core
);

   // register map and pin bus are fixed at eight lines
   if (LINES != 8 || PULSE_MIN_CYC < 1) begin : g_cfg_check
      $error("eiu_ext_irq: unsupported configuration");
   end

   // one-hot select {lower sense, upper sense, mask, flags}
   function automatic logic [3:0] eiu_decode(
      input logic [EIU_ADDR_W-1:0] a
   );
      logic [9:0] idx;
      idx = a[EIU_ADDR_W-1:2];
      eiu_decode = {idx == IDX_SENSE_LO, idx == IDX_SENSE_HI,
                    idx == IDX_MASK, idx == IDX_FLAGS};
   endfunction

   function automatic logic [1:0] eiu_sense_of(
      input logic [15:0] s,
      input int          n
   );
      eiu_sense_of = s[SENSE_W*n +: SENSE_W];
   endfunction

   // edge or change hit between two successive samples
   function automatic logic eiu_hit(
      input logic [1:0] s,
      input logic       upper,
      input logic       cur,
      input logic       prev
   );
      logic h;
      h = 1'b0;
      unique case (s)
         SENSE_LEVEL:  h = 1'b0;
         SENSE_CHANGE: h = upper & (cur ^ prev);
         SENSE_FALL:   h = prev & ~cur;
         SENSE_RISE:   h = ~prev & cur;
      endcase
      eiu_hit = h;
   endfunction

   logic [7:0]  flags_q;
   logic [7:0]  flags_d;
   logic [7:0]  mask_q;
   logic [7:0]  sense_hi_q;
   logic [7:0]  sense_lo_q;
   logic [7:0]  sync1_q;
   logic [7:0]  sync2_q;
   logic [7:0]  prev_q;
   logic [7:0]  pin_eff;
   logic [7:0]  level_mask;
   logic [7:0]  hit_mask;
   logic [7:0]  set_mask;
   logic [7:0]  clr_mask;
   logic [7:0]  req_d;
   logic [15:0] sense_all;
   logic [3:0]  sel;
   logic        access;
   logic        take;
   logic        commit_wr;
   logic        wr_flags;
   logic        wr_lo_ok;
   logic [7:0]  wdata;
   logic [7:0]  rdata;

   // apb decode
   assign access    = i_apb.psel & i_apb.penable;
   assign take      = access & ~o_apb.pready;
   assign commit_wr = access & o_apb.pready & i_apb.pwrite;
   assign sel       = eiu_decode(i_apb.paddr);
   assign wdata     = i_apb.pwdata[7:0];
   assign wr_flags  = commit_wr & sel[0];
   assign wr_lo_ok  = commit_wr & sel[3] & ~i_compat_mode;

   always_comb begin
      rdata = 8'h00;
      unique case (1'b1)
         sel[0]: rdata = flags_q;
         sel[1]: rdata = mask_q;
         sel[2]: rdata = sense_hi_q;
         sel[3]: rdata = i_compat_mode ? 8'h00 : sense_lo_q;
         default: rdata = 8'h00;
      endcase
   end

   // one wait state, then pready for one cycle
   // registered answer costs a cycle but keeps outputs on flops
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         o_apb <= '0;
      end else begin
         o_apb.pready  <= take;
         o_apb.pslverr <= take & ~(|sel);
         o_apb.prdata  <= (take & ~i_apb.pwrite) ? {24'h000000, rdata}
                                                  : 32'h00000000;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         mask_q     <= RST_MASK;
         sense_hi_q <= RST_SENSE;
         sense_lo_q <= RST_SENSE;
      end else begin
         if (commit_wr & sel[1]) begin
            mask_q <= wdata;
         end
         if (commit_wr & sel[2]) begin
            sense_hi_q <= wdata;
         end
         if (wr_lo_ok) begin
            sense_lo_q <= wdata;
         end
      end
   end

   // sleep clamps disabled low lines to zero
   // clamp before the synchronizer so its fall looks like a pin edge
   assign pin_eff = i_ext_irq_pins &
                    ~{4'h0, {4{i_sleep}} & ~mask_q[3:0]};

   // pin level used regardless of direction
   // two-stage synchronizer then one more sample
   // every line needs the clock here; no clockless wake path
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         sync1_q <= 8'hff;
         sync2_q <= 8'hff;
         prev_q  <= 8'hff;
      end else begin
         sync1_q <= pin_eff;
         sync2_q <= sync1_q;
         prev_q  <= sync2_q;
      end
   end

   assign sense_all = {sense_hi_q, sense_lo_q};

   // low lines sampled too: 50 ns equals one clock here
   // pulse over one period lands in a sample
   always_comb begin
      level_mask = 8'h00;
      hit_mask   = 8'h00;
      for (int n = 0; n < EIU_LINES; n++) begin
         level_mask[n] = (eiu_sense_of(sense_all, n) == SENSE_LEVEL);
         hit_mask[n]   = eiu_hit(eiu_sense_of(sense_all, n),
                                 n >= FIRST_UPPER,
                                 sync2_q[n], prev_q[n]);
      end
   end

   assign set_mask = hit_mask & ~level_mask;
   assign clr_mask = (wr_flags ? wdata : 8'h00) |
                     (i_vector_taken ? 8'(8'h01 << i_vector_line)
                                     : 8'h00);

   // set wins over clear; level lines forced zero
   // level keeps flag zero
   assign flags_d = ((flags_q & ~clr_mask) | set_mask) & ~level_mask;

   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         flags_q <= RST_FLAGS;
      end else begin
         flags_d_apply: flags_q <= flags_d;
      end
   end

   // request: flag or low level, gated by enable
   always_comb begin
      for (int n = 0; n < EIU_LINES; n++) begin
         req_d[n] = mask_q[n] &
                    (level_mask[n] ? ~sync2_q[n] : flags_q[n]);
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         o_line_request <= 8'h00;
         o_irq          <= 1'b0;
      end else begin
         o_line_request <= req_d;
         o_irq          <= i_global_irq_enable & (|req_d);
      end
   end

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_reset);

   property p_level_flag_zero;
      1'b1 |=> ((flags_q & $past(level_mask)) == 8'h00);
   endproperty
   a_level_flag_zero: assert property (p_level_flag_zero)
      else $error("level line holds a flag");

   property p_hit_sets;
      (set_mask != 8'h00) |=>
         ((flags_q & $past(set_mask)) == $past(set_mask));
   endproperty
   a_hit_sets: assert property (p_hit_sets)
      else $error("edge did not set flag");

   property p_w1c;
      (wr_flags && ((wdata & ~set_mask) != 8'h00)) |=>
         ((flags_q & $past(wdata & ~set_mask)) == 8'h00);
   endproperty
   a_w1c: assert property (p_w1c)
      else $error("write one did not clear flag");

   property p_w0_keeps;
      (wr_flags && !i_vector_taken) |=>
         ((flags_q & ~$past(wdata)) == 
          (($past(flags_q) | $past(set_mask)) & ~$past(level_mask)
           & ~$past(wdata)));
   endproperty
   a_w0_keeps: assert property (p_w0_keeps)
      else $error("write zero changed flag");

   property p_vector_clear;
      (i_vector_taken && !set_mask[i_vector_line]) |=>
         !flags_q[$past(i_vector_line)];
   endproperty
   a_vector_clear: assert property (p_vector_clear)
      else $error("vector taken left flag set");

   property p_global_gate;
      !i_global_irq_enable |=> !o_irq;
   endproperty
   a_global_gate: assert property (p_global_gate)
      else $error("irq without global enable");

   property p_irq_cause;
      (i_global_irq_enable && (req_d != 8'h00)) |=> o_irq;
   endproperty
   a_irq_cause: assert property (p_irq_cause)
      else $error("enabled request missed irq");

   property p_level_req;
      ((level_mask & mask_q & ~sync2_q) != 8'h00) |=>
         (o_line_request != 8'h00);
   endproperty
   a_level_req: assert property (p_level_req)
      else $error("low level gave no request");

   property p_req_masked;
      1'b1 |=> ((o_line_request & ~$past(mask_q)) == 8'h00);
   endproperty
   a_req_masked: assert property (p_req_masked)
      else $error("request on disabled line");

   property p_pin_to_flag;
      ($fell(sync1_q[4]) && sense_hi_q[1:0] == SENSE_FALL
       && !wr_flags && !(commit_wr && sel[2])) |=> ##1 flags_q[4];
   endproperty
   a_pin_to_flag: assert property (p_pin_to_flag)
      else $error("sampled fall did not flag");

   property p_compat_lock;
      (commit_wr && sel[3] && i_compat_mode) |=> $stable(sense_lo_q);
   endproperty
   a_compat_lock: assert property (p_compat_lock)
      else $error("lower sense written in legacy mode");

   property p_apb_wait;
      take |=> o_apb.pready ##1 !o_apb.pready;
   endproperty
   a_apb_wait: assert property (p_apb_wait)
      else $error("apb answer timing wrong");

   // detection chain, register side and request outputs
   property p_reserved_quiet;
      (sense_lo_q[3:2] == SENSE_CHANGE && !flags_q[1]) |=> !flags_q[1];
   endproperty
   a_reserved_quiet: assert property (p_reserved_quiet)
      else $error("reserved sense code raised a flag");

   property p_upper_change;
      ($changed(sync2_q[5]) && sense_hi_q[3:2] == SENSE_CHANGE) |=>
         flags_q[5];
   endproperty
   a_upper_change: assert property (p_upper_change)
      else $error("pin change did not flag");

   property p_sync_chain;
      1'b1 |=> ((sync2_q == $past(sync1_q)) &&
                (prev_q == $past(sync2_q)));
   endproperty
   a_sync_chain: assert property (p_sync_chain)
      else $error("synchronizer skipped a stage");

   property p_sleep_clamp;
      i_sleep |=> ((sync1_q[3:0] & ~$past(mask_q[3:0])) == 4'h0);
   endproperty
   a_sleep_clamp: assert property (p_sleep_clamp)
      else $error("sleep did not clamp disabled line");

   property p_sense_write;
      (commit_wr && sel[2]) |=> (sense_hi_q == $past(wdata));
   endproperty
   a_sense_write: assert property (p_sense_write)
      else $error("upper sense write lost");

   property p_req_flag;
      (!level_mask[4] && mask_q[4] && flags_q[4]) |=> o_line_request[4];
   endproperty
   a_req_flag: assert property (p_req_flag)
      else $error("flagged line gave no request");

   property p_irq_quiet;
      (req_d == 8'h00) |=> !o_irq;
   endproperty
   a_irq_quiet: assert property (p_irq_quiet)
      else $error("irq with no line request");

   property p_compat_read;
      (take && sel[3] && i_compat_mode) |=> (o_apb.prdata == 32'h00000000);
   endproperty
   a_compat_read: assert property (p_compat_read)
      else $error("lower sense visible in legacy mode");

endmodule

// ===== dv/eiu_pin_src.sv
// model of the sources that drive the eight interrupt pins
`timescale 1ns/100ps
module eiu_pin_src (
   input  wire logic       i_clock, // bench clock
   output logic [7:0]      o_pins   // pins, idle high as if pulled up
);
   initial o_pins = 8'hff;

   task automatic pulse(input int line, input int cyc);
      @(posedge i_clock);
      o_pins[line] <= 1'b0;
      repeat (cyc) @(posedge i_clock);
      o_pins[line] <= 1'b1;
   endtask

   task automatic hold(input int line, input logic v);
      @(posedge i_clock);
      o_pins[line] <= v;
   endtask
endmodule

// ===== dv/external_pin_interrupt_unit_tb.sv
// self-checking bench for the external pin interrupt unit
`timescale 1ns/100ps
module external_pin_interrupt_unit_tb;
   import eiu_pkg::*;
   logic         clk = 1'b0;
   logic         rst = 1'b1;
   logic         gie = 1'b0;
   logic         vt  = 1'b0;
   logic         slp = 1'b0;
   logic         cmp = 1'b0;
   logic [2:0]   vl  = 3'h0;
   eiu_apb_req_t req = '0;
   eiu_apb_rsp_t rsp;
   logic [7:0]   pins;
   logic [7:0]   lreq;
   logic         irq;
   logic [31:0]  rd;
   logic         er;
   int           miscompares = 0;
   int           checks_done = 0;

   always #25 clk = ~clk;

   eiu_pin_src src (.i_clock(clk), .o_pins(pins));

   eiu_ext_irq dut (
      .i_clock(clk), .i_reset(rst), .i_apb(req), .o_apb(rsp),
      .i_ext_irq_pins(pins), .i_global_irq_enable(gie),
      .i_vector_taken(vt), .i_vector_line(vl), .i_sleep(slp),
      .i_compat_mode(cmp), .o_line_request(lreq), .o_irq(irq));

   task automatic report_and_stop;
      if (miscompares == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // apb transfer; a wait of 20 cycles without pready ends the run
   task automatic rw(input logic w, input logic [9:0] idx,
                     input logic [7:0] wd);
      int n;
      n = 0;
      @(posedge clk);
      req <= '{1'b1, 1'b0, w, {idx, 2'b00}, {24'h0, wd}};
      @(posedge clk);
      req.penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (rsp.pready !== 1'b1 && n < 20);
      if (rsp.pready !== 1'b1) begin
         miscompares++;
         report_and_stop();
      end else begin
         rd = rsp.prdata;
         er = rsp.pslverr;
         req <= '0;
      end
   endtask

   task automatic rdc(input logic [9:0] idx, input logic [7:0] exp);
      rw(1'b0, idx, 8'h00);
      chk(rd, {24'h0, exp});
   endtask

   task automatic t_reset;
      rdc(IDX_FLAGS, 8'h00);
      rdc(IDX_MASK, 8'h00);
      rdc(IDX_SENSE_HI, 8'h00);
      rdc(IDX_SENSE_LO, 8'h00);
      rdc(10'h001, 8'h00);
      chk(er, 1'b1);
   endtask

   task automatic t_edge;
      rw(1'b1, IDX_SENSE_HI, {6'h0, SENSE_FALL});
      rw(1'b1, IDX_FLAGS, 8'h10);
      rw(1'b1, IDX_MASK, 8'h10);
      gie <= 1'b1;
      src.pulse(4, 2);
      repeat (8) @(posedge clk);
      chk(lreq, 8'h10);
      chk(irq, 1'b1);
      rdc(IDX_FLAGS, 8'h10);
      rw(1'b1, IDX_FLAGS, 8'h00);
      rdc(IDX_FLAGS, 8'h10);
      rw(1'b1, IDX_FLAGS, 8'h10);
      rdc(IDX_FLAGS, 8'h00);
      gie <= 1'b0;
      src.pulse(4, 2);
      repeat (8) @(posedge clk);
      chk(irq, 1'b0);
      chk(lreq, 8'h10);
      rdc(IDX_FLAGS, 8'h10);
      vt <= 1'b1;
      vl <= 3'h4;
      @(posedge clk);
      vt <= 1'b0;
      rdc(IDX_FLAGS, 8'h00);
   endtask

   task automatic t_modes;
      rw(1'b1, IDX_SENSE_HI, {2'h0, SENSE_RISE, SENSE_CHANGE, 2'h0});
      rw(1'b1, IDX_SENSE_LO, {4'h0, SENSE_CHANGE, SENSE_RISE});
      src.hold(5, 1'b0);
      src.hold(1, 1'b0);
      src.pulse(0, 2);
      src.pulse(6, 2);
      repeat (8) @(posedge clk);
      rdc(IDX_FLAGS, 8'h61);
      src.hold(5, 1'b1);
      src.hold(1, 1'b1);
      rw(1'b1, IDX_FLAGS, 8'hff);
   endtask

   task automatic t_level;
      rw(1'b1, IDX_SENSE_LO, 8'h00);
      rw(1'b1, IDX_MASK, 8'h01);
      gie <= 1'b1;
      src.hold(0, 1'b0);
      repeat (10) @(posedge clk);
      chk(lreq, 8'h01);
      chk(irq, 1'b1);
      rdc(IDX_FLAGS, 8'h00);
      src.hold(0, 1'b1);
      repeat (8) @(posedge clk);
      chk(lreq, 8'h00);
   endtask

   task automatic t_sleep;
      rw(1'b1, IDX_MASK, 8'h00);
      rw(1'b1, IDX_SENSE_LO, {2'h0, SENSE_FALL, 4'h0});
      slp <= 1'b1;
      repeat (8) @(posedge clk);
      rdc(IDX_FLAGS, 8'h04);
      slp <= 1'b0;
      rw(1'b1, IDX_FLAGS, 8'hff);
   endtask

   task automatic t_compat;
      cmp <= 1'b1;
      rw(1'b1, IDX_SENSE_LO, 8'hff);
      chk(er, 1'b0);
      rdc(IDX_SENSE_LO, 8'h00);
      cmp <= 1'b0;
      rdc(IDX_SENSE_LO, {2'h0, SENSE_FALL, 4'h0});
   endtask

   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      t_reset();
      t_edge();
      t_modes();
      t_level();
      t_sleep();
      t_compat();
      report_and_stop();
   end
endmodule
